// [shared/nbh_defines.vh]
`ifndef NBH_DEFINES_VH
`define NBH_DEFINES_VH
// Bus op codes from the user side
`define NBH_OP_CMD 2'h0
`define NBH_OP_ADDR 2'h1
`define NBH_OP_WRITE 2'h2
`define NBH_OP_READ 2'h3
// Address layout
`define NBH_ADDR_CYCLES 3'h5
`define NBH_COL_BITS 12
`define NBH_ROW_BITS 17
`define NBH_PLANE_BIT 6
// Array geometry
`define NBH_BLOCKS 2048
`define NBH_PAGES_PER_BLOCK 64
`define NBH_PAGE_BYTES 2112
`define NBH_MAIN_BYTES 2048
`define NBH_SPARE_BYTES 64
// Strobe timing: each strobe phase lasts this many 20 ns cycles
`define NBH_CLK_NS 20
`define NBH_PHASE_NS 25
`define NBH_PHASE_CYC ((`NBH_PHASE_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
// Read setup command assumed latched at power-on
`define NBH_CMD_READ_SETUP 8'h00
// FIFO shape
`define NBH_FIFO_W 8
`define NBH_FIFO_D 4
`endif

// [src/nbh_fifo.v]
`timescale 1ns/10ps
// Small synchronous FIFO with valid/ready on both sides
module nbh_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Fill side
  input wire i_valid,
  input wire [W-1:0] i_data,
  output wire o_ready,
  // Drain side
  output wire o_valid,
  output wire [W-1:0] o_data,
  input wire i_ready
);
  reg [W-1:0] mem [0:D-1]; // Storage
  reg [AW-1:0] wr_ptr; // Write index
  reg [AW-1:0] rd_ptr; // Read index
  reg [AW:0] count; // Fill level
  wire push;
  wire pop;
  assign o_ready = (count != D[AW:0]);
  assign o_valid = (count != {(AW+1){1'b0}});
  assign o_data = mem[rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  // Storage write
  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end
  // Pointer and level bookkeeping
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // nbh_fifo

// [src/nbh_host.v]
`timescale 1ns/10ps
`include "nbh_defines.vh"
module nbh_host (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // User request
  input wire i_req_valid,
  input wire [1:0] i_req_op,
  input wire [7:0] i_req_byte,
  input wire i_req_last,
  input wire i_wp_release,
  output wire o_req_ready,
  // Address assembly request
  input wire i_addr_valid,
  input wire [11:0] i_addr_col,
  input wire [16:0] i_addr_row,
  output wire o_addr_ready,
  // Read data out
  output wire o_rd_valid,
  output wire [7:0] o_rd_data,
  input wire i_rd_ready,
  // Status
  output reg o_busy_seen,
  output wire o_idle,
  output reg o_plane,
  // Flash pins
  output reg o_cmd_latch,
  output reg o_addr_latch,
  output reg o_chip_select_n,
  output reg o_write_strobe_n,
  output reg o_read_strobe_n,
  output reg o_write_protect_n,
  input wire i_ready_busy_n,
  input wire [7:0] i_dq,
  output reg [7:0] o_dq,
  output reg o_dq_oe
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_LOW = 3'h2;
  localparam ST_HIGH = 3'h3;
  localparam ST_WAIT = 3'h4;
  localparam ST_NEXT = 3'h5;
  reg [2:0] state; // Sequencer state
  reg [1:0] op; // Operation in flight
  reg [7:0] cur_byte; // Byte on the bus
  reg [2:0] addr_idx; // Address cycle in progress, 0 none
  reg [39:0] addr_sr; // Packed five address bytes
  reg [1:0] tcnt; // Phase timer
  reg last; // Chip select released after this cycle
  reg [7:0] rd_byte; // Read byte caught while the read strobe is still low
  wire fifo_ready;
  reg fifo_push;
  wire phase_done;
  assign phase_done = (tcnt == `NBH_PHASE_CYC - 1);
  assign o_idle = (state == ST_IDLE) && (addr_idx == 3'h0);
  assign o_req_ready = o_idle && !(i_req_op == `NBH_OP_READ && !fifo_ready);
  assign o_addr_ready = o_idle;
  // ----------------------------------------
  // Read data buffer
  // ----------------------------------------
  nbh_fifo #(
    .W(`NBH_FIFO_W),
    .D(`NBH_FIFO_D),
    .AW(2)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_valid(fifo_push),
    .i_data(rd_byte),
    .o_ready(fifo_ready),
    .o_valid(o_rd_valid),
    .o_data(o_rd_data),
    .i_ready(i_rd_ready)
  );
  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      op <= `NBH_OP_CMD;
      cur_byte <= 8'h00;
      addr_idx <= 3'h0;
      addr_sr <= 40'h0;
      tcnt <= 2'h0;
      last <= 1'b1;
      fifo_push <= 1'b0;
      rd_byte <= 8'h00;
      o_busy_seen <= 1'b0;
      o_plane <= 1'b0;
      o_cmd_latch <= 1'b0;
      o_addr_latch <= 1'b0;
      o_chip_select_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_write_protect_n <= 1'b0;
      o_dq <= 8'h00;
      o_dq_oe <= 1'b0;
    end else begin
      fifo_push <= 1'b0;
      // Protect follows the user level except while a busy is pending
      if (state != ST_WAIT) begin
        o_write_protect_n <= i_wp_release;
      end
      case (state)
        ST_IDLE: begin
          tcnt <= 2'h0;
          if (addr_idx != 3'h0) begin
            // Next address byte of the five
            op <= `NBH_OP_ADDR;
            cur_byte <= addr_sr[7:0];
            addr_sr <= {8'h00, addr_sr[39:8]};
            last <= 1'b0;
            state <= ST_SETUP;
          end else if (i_addr_valid) begin
            // column low first, then row low first
            addr_sr <= {7'h00, i_addr_row, 4'h0, i_addr_col};
            o_plane <= i_addr_row[`NBH_PLANE_BIT];
            addr_idx <= `NBH_ADDR_CYCLES;
          end else if (i_req_valid && o_req_ready) begin
            op <= i_req_op;
            cur_byte <= i_req_byte;
            last <= i_req_last;
            state <= ST_SETUP;
          end else if (last) begin
            o_chip_select_n <= 1'b1;
            o_cmd_latch <= 1'b0;
            o_addr_latch <= 1'b0;
          end
        end
        ST_SETUP: begin
          o_chip_select_n <= 1'b0;
          o_cmd_latch <= (op == `NBH_OP_CMD);
          o_addr_latch <= (op == `NBH_OP_ADDR);
          o_dq <= cur_byte;
          o_dq_oe <= (op != `NBH_OP_READ);
          tcnt <= 2'h0;
          state <= ST_LOW;
        end
        ST_LOW: begin
          // read strobe low, else write strobe low
          if (op == `NBH_OP_READ) begin
            o_read_strobe_n <= 1'b0;
          end else begin
            o_write_strobe_n <= 1'b0;
          end
          tcnt <= tcnt + 2'h1;
          if (phase_done) begin
            tcnt <= 2'h0;
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // rising write strobe latches the byte
          // Catch the byte before the strobe rises; the die may change the bus after
          if (o_read_strobe_n == 1'b0) begin
            fifo_push <= 1'b1;
            rd_byte <= i_dq;
          end
          o_write_strobe_n <= 1'b1;
          o_read_strobe_n <= 1'b1;
          tcnt <= tcnt + 2'h1;
          if (phase_done) begin
            tcnt <= 2'h0;
            o_dq_oe <= 1'b0;
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          // exactly five address cycles, no extras
          if (addr_idx != 3'h0) begin
            addr_idx <= addr_idx - 3'h1;
          end
          if (op == `NBH_OP_CMD && last) begin
            state <= ST_WAIT;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          // hold read strobe high and protect at its last value while busy
          o_read_strobe_n <= 1'b1;
          o_cmd_latch <= 1'b0;
          if (!i_ready_busy_n) begin
            o_busy_seen <= 1'b1;
          end
          tcnt <= (tcnt == 2'h3) ? tcnt : tcnt + 2'h1;
          if (i_ready_busy_n && tcnt == 2'h3) begin
            o_busy_seen <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // nbh_host

// [tb/nbh_flash_model.sv]
`timescale 1ns/10ps
// Behavioural flash die on the far side
module nbh_flash_model (
  input wire i_cmd_latch, i_addr_latch, i_cs_n, i_we_n, i_re_n, i_wp_n,
  input wire [7:0] i_dq,
  output reg o_rb_n,
  output reg [7:0] o_dq
);
  reg [7:0] cmd, prev, wdata;
  reg [7:0] abyte [0:4];
  reg [2:0] acnt;
  // page column spans 2048 main plus 64 spare bytes
  reg [11:0] col;
  integer prog_cnt;
  wire plane = abyte[2][6];
  initial begin
    o_rb_n = 1'b1; acnt = 3'h0; cmd = 8'h00; prog_cnt = 0; o_dq = 8'h00;
  end
  task busy; begin o_rb_n = 1'b0; #300; o_rb_n = 1'b1; end endtask
  // capture on write strobe rise; standby ignores strobes
  always @(posedge i_we_n) if (!i_cs_n) begin
    if (i_cmd_latch) begin
      prev = cmd; cmd = i_dq; acnt = 3'h0;
      if (i_dq == 8'h30) begin col = {abyte[1][3:0], abyte[0]}; busy; end
      if (i_dq == 8'h10 && prev == 8'h80 && i_wp_n) begin prog_cnt = prog_cnt + 1; busy; end
    end else if (i_addr_latch) begin
      if (acnt < 3'h5) begin abyte[acnt] = i_dq; acnt = acnt + 3'h1; end
    end else if (i_wp_n) wdata = i_dq;
  end
  // read byte out, released bus shows inverse
  always @(negedge i_re_n) if (!i_cs_n) o_dq = col[7:0] ^ 8'h5A;
  always @(posedge i_re_n) if (!i_cs_n) begin o_dq = ~o_dq; col = col + 12'h001; end
endmodule // nbh_flash_model

// [tb/nbh_host_chk.sv]
`timescale 1ns/10ps
// Protocol watcher on the host pins
module nbh_host_chk (
  input wire i_clk, i_rstn, i_addr_valid, i_wp_release, i_ready_busy_n, o_idle, o_plane,
  input wire o_cmd_latch, o_addr_latch, o_chip_select_n, o_write_strobe_n,
  input wire o_read_strobe_n, o_write_protect_n, o_dq_oe,
  input wire [16:0] i_addr_row,
  input wire [7:0] o_dq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Address strobes since the last command strobe
  reg [2:0] acnt;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) acnt <= 3'h0;
    else if ($rose(o_write_strobe_n)) acnt <= o_cmd_latch ? 3'h0 : acnt + {2'h0, o_addr_latch};
  end
  sequence s_hold;
    (!o_write_strobe_n && $stable(o_dq) && $stable(o_addr_latch))
    ##1 (o_write_strobe_n && $stable(o_dq) && $stable(o_cmd_latch));
  endsequence
  property p_cs; !o_write_strobe_n |-> !o_chip_select_n; endproperty
  a_cs: assert property (p_cs) else $error("strobe outside select");
  property p_excl; !(o_cmd_latch && o_addr_latch); endproperty
  a_excl: assert property (p_excl) else $error("both latches high");
  property p_rd; !o_read_strobe_n |-> !o_cmd_latch && !o_addr_latch && !o_dq_oe; endproperty
  a_rd: assert property (p_rd) else $error("bad read phase");
  property p_drv; !o_write_strobe_n |-> o_dq_oe; endproperty
  a_drv: assert property (p_drv) else $error("bus not driven");
  property p_pulse; $fell(o_write_strobe_n) |=> s_hold; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe pulse wrong");
  property p_busy; !i_ready_busy_n |-> o_read_strobe_n; endproperty
  a_busy: assert property (p_busy) else $error("read strobe in busy");
  property p_wp; (!i_wp_release && o_idle) [*3] |-> !o_write_protect_n; endproperty
  a_wp: assert property (p_wp) else $error("protect not low");
  property p_plane; i_addr_valid && o_idle |=> o_plane == $past(i_addr_row[6]); endproperty
  a_plane: assert property (p_plane) else $error("plane bit wrong");
  property p_pad; o_addr_latch && !o_write_strobe_n && (acnt == 3'h1 || acnt == 3'h4)
    |-> o_dq[7:4] == 4'h0 && (acnt == 3'h1 || o_dq[3:1] == 3'h0); endproperty
  a_pad: assert property (p_pad) else $error("unused address bits set");
  property p_five; acnt <= 3'h5; endproperty
  a_five: assert property (p_five) else $error("too many address bytes");
endmodule // nbh_host_chk
bind nbh_host nbh_host_chk u_chk (.*);

// [tb/tb.sv]
`timescale 1ns/10ps
`include "nbh_defines.vh"
`define CHK(a,e) begin check_count=check_count+1; if ((a)!==(e)) begin err_total=err_total+1; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
  reg i_clk = 0, i_rstn = 0, rv = 0, rl = 0, wpr = 0, av = 0, rdr = 0;
  reg [1:0] rop = 0;
  reg [7:0] rb = 0, e;
  reg [11:0] acol = 0;
  reg [16:0] arow = 0;
  integer err_total = 0, check_count = 0, i, n, k, p;
  wire rdy, rdv, bsy, idle, pl, cl, al, cs_n, we_n, re_n, wp_n, rb_n, oe;
  wire [7:0] rdd, hdq, fdq;
  // Shared bus: host when enabled, else the die
  wire [7:0] dq = oe ? hdq : fdq;
  nbh_host dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(rv), .i_req_op(rop),
    .i_req_byte(rb), .i_req_last(rl), .i_wp_release(wpr), .o_req_ready(rdy),
    .i_addr_valid(av), .i_addr_col(acol), .i_addr_row(arow), .o_addr_ready(),
    .o_rd_valid(rdv), .o_rd_data(rdd), .i_rd_ready(rdr), .o_busy_seen(bsy), .o_idle(idle),
    .o_plane(pl), .o_cmd_latch(cl), .o_addr_latch(al), .o_chip_select_n(cs_n),
    .o_write_strobe_n(we_n), .o_read_strobe_n(re_n), .o_write_protect_n(wp_n),
    .i_ready_busy_n(rb_n), .i_dq(dq), .o_dq(hdq), .o_dq_oe(oe));
  nbh_flash_model fm (.i_cmd_latch(cl), .i_addr_latch(al), .i_cs_n(cs_n), .i_we_n(we_n),
    .i_re_n(re_n), .i_wp_n(wp_n), .i_dq(dq), .o_rb_n(rb_n), .o_dq(fdq));
  initial forever #10 i_clk = ~i_clk;
  // One user request, held until taken
  task req(input [1:0] op, input [7:0] b, input l); begin
    @(negedge i_clk); rv = 1; rop = op; rb = b; rl = l; n = 0;
    @(posedge i_clk); while (rdy !== 1'b1 && n < 300) begin n = n + 1; @(posedge i_clk); end
    @(negedge i_clk); rv = 0;
  end endtask
  task addr(input [11:0] c, input [16:0] r); begin
    @(negedge i_clk); av = 1; acol = c; arow = r; n = 0;
    @(posedge i_clk); while (idle !== 1'b1 && n < 300) begin n = n + 1; @(posedge i_clk); end
    @(negedge i_clk); av = 0;
  end endtask
  task wait_idle; begin
    n = 0; repeat (2) @(posedge i_clk);
    while (idle !== 1'b1 && n < 300) begin n = n + 1; @(posedge i_clk); end
  end endtask
  // Page read without setup command, fill FIFO to refusal, drain
  task t_read; begin
    addr(12'h7F3, 17'h10040);
    req(`NBH_OP_CMD, 8'h30, 1'b1);
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    `CHK(bsy, 1'b1)
    wait_idle;
    `CHK(fm.abyte[0], 8'hF3)
    `CHK(fm.abyte[1], 8'h07)
    `CHK(fm.abyte[4], 8'h01)
    `CHK(pl, 1'b1)
    for (i = 0; i < 4; i = i + 1) req(`NBH_OP_READ, 8'h00, 1'b0);
    wait_idle;
    @(negedge i_clk); rv = 1; rop = `NBH_OP_READ; rl = 1;
    repeat (8) @(posedge i_clk);
    `CHK(rdy, 1'b0)
    @(negedge i_clk); rdr = 1; k = 0; n = 0;
    while (k < 5 && n < 300) begin
      @(posedge i_clk); n = n + 1;
      if (rv && rdy === 1'b1) rv <= 0;
      if (rdv === 1'b1) begin
        e = (8'hF3 + k[7:0]) ^ 8'h5A;
        `CHK(rdd, e)
        k = k + 1;
      end
    end
    `CHK(k, 5)
    wait_idle;
  end endtask
  // Program with protect held or released
  task t_prog(input w); begin
    @(negedge i_clk); wpr = w; p = fm.prog_cnt;
    req(`NBH_OP_CMD, 8'h80, 1'b0); addr(12'h010, 17'h00002);
    req(`NBH_OP_WRITE, 8'hC5, 1'b0); req(`NBH_OP_CMD, 8'h10, 1'b1);
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    `CHK(bsy, w)
    wait_idle;
    `CHK(wp_n, w)
    `CHK(fm.prog_cnt, p + w)
    `CHK(fm.cmd, 8'h10)
    `CHK(fm.abyte[2], 8'h02)
    `CHK(pl, 1'b0)
    if (w) `CHK(fm.wdata, 8'hC5)
  end endtask
  task tally_and_finish; begin
    $display("errors=%0d checks=%0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end endtask
  initial begin
    repeat (5) @(posedge i_clk);
    @(negedge i_clk); i_rstn = 1;
    t_read; t_prog(1'b0); t_prog(1'b1);
    tally_and_finish;
  end
  // Watchdog far beyond the expected run
  initial begin #200000; err_total = err_total + 1; tally_and_finish; end
endmodule // tb
